// ### hdl/adapter_status_regs.sv
// status, transfer data and maintenance registers of the channel adapter
`timescale 1ns/1ps
module adapter_status_regs #(
  parameter longint RESP_TIMEOUT = adapter_regs_pkg::RESP_TIMEOUT_CYCLES,
  parameter int GRANT_TIMEOUT = adapter_regs_pkg::GRANT_TIMEOUT_CYCLES,
  parameter int BUF_DEPTH = 2
)
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire adapter_regs_pkg::host_req_t HOST_REQ_IN,
  input wire logic HOST_STROBE_IN,
  output logic [15:0] HOST_RDATA_OUT,
  input wire logic CB_CLEAR_IN,
  input wire logic ONLINE_REQUEST_IN,
  input wire logic [15:0] BUFFER_START_ADDRESS_IN,
  input wire logic [2:0] PHASE_IN,
  input wire logic MEM_START_IN,
  input wire logic MEM_WRITE_IN,
  input wire logic [15:0] MEM_WDATA_IN,
  input wire logic STATUS_PENDING_IN,
  input wire logic BYTE_STEP_IN,
  input wire logic [15:0] BUS_OUT_IN,
  input wire logic [7:0] CU_ADDRESS_IN,
  input wire logic [7:0] DEV_ADDRESS_IN,
  input wire logic OPERATIONAL_IN_IN,
  input wire logic SERVICE_IN_IN,
  input wire logic DISCONNECT_IN,
  input wire logic CHANNEL_RESET_IN,
  input wire logic GRANT_IN,
  input wire logic [15:0] MEM_RDATA_IN,
  input wire logic MEM_DONE_IN,
  input wire logic WORD_READY_IN,
  output logic WORD_VALID_OUT,
  output adapter_regs_pkg::mem_word_t WORD_OUT,
  output logic MEM_BUSY_OUT,
  output logic MEM_REQUEST_OUT,
  output logic [15:0] RESULT_ADDRESS_OUT,
  output logic SKIP_FETCH_OUT,
  output logic SIM_SERVICE_OUT_OUT,
  output logic TIME_STEP_OUT,
  output logic RESET_RECALL_OUT
);
  import adapter_regs_pkg::*;

  typedef struct packed {
    mem_state_t mst;
    logic mem_req;
    logic dir;
    logic byte_alt;
    logic online_lvl;
    logic [15:0] xfer_word;
    logic [7:0] next_index;
    logic grant_err;
    logic resp_err;
    logic timer_dis;
    logic fast_test;
    logic mclk_en;
    logic mclk_pulse;
    logic disc_seen;
    logic reset_stored;
    logic [63:0] resp_cnt;
    logic [31:0] grant_cnt;
    logic sim_channel_service_out;
    logic step;
    logic [15:0] rdata;
  } regs_state_t;

  regs_state_t s_r;
  regs_state_t s_nxt;
  logic channel_operational_in;
  logic channel_service_in;
  logic disc;
  logic chrst;
  logic cu_match;
  logic dev_match;
  logic buf_in_ready;
  logic buf_in_valid;
  logic host_wr;
  // grant timeout firing this cycle; a write-one-to-clear loses to it
  logic grant_evt;
  logic [15:0] cb_word;
  logic [15:0] es1_word;
  logic [15:0] es2_word;
  mem_word_t buf_word;

  pin_sync u_sync_opl (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .pin_in(OPERATIONAL_IN_IN),
    .level_out(channel_operational_in));
  pin_sync u_sync_channel_service_in (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .pin_in(SERVICE_IN_IN),
    .level_out(channel_service_in));
  pin_sync u_sync_disc (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .pin_in(DISCONNECT_IN),
    .level_out(disc));
  pin_sync u_sync_rst (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .pin_in(CHANNEL_RESET_IN),
    .level_out(chrst));

  // comparator is purely combinational, no latching
  assign cu_match = (BUS_OUT_IN[15:8] == CU_ADDRESS_IN);
  assign dev_match = cu_match && (BUS_OUT_IN[7:0] == DEV_ADDRESS_IN);

  assign cb_word = {10'h000, s_r.mem_req, s_r.dir, s_r.byte_alt, s_r.online_lvl,
    cu_match, dev_match};
  assign es1_word = {s_r.next_index, 1'b0, BUFFER_START_ADDRESS_IN[0], s_r.grant_err,
    s_r.resp_err, s_r.timer_dis, s_r.fast_test, s_r.mclk_en, s_r.mclk_pulse};
  assign es2_word = {14'h0000, s_r.disc_seen, s_r.reset_stored};
  assign host_wr = HOST_STROBE_IN && HOST_REQ_IN.write;
  assign grant_evt = (s_r.mst == MR_WAIT) && !GRANT_IN
    && (s_r.grant_cnt >= 32'(GRANT_TIMEOUT - 1));

  // words land in the buffer so a stalled consumer drops nothing
  assign buf_in_valid = (s_r.mst == MR_WAIT) && MEM_DONE_IN;
  assign buf_word.data = s_r.dir ? s_r.xfer_word : MEM_RDATA_IN;
  assign buf_word.write = s_r.dir;

  word_buffer #(.WIDTH($bits(mem_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
    .CLK_IN(CLK_IN),
    .RSTN_IN(RSTN_IN),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in(buf_word),
    .out_valid_out(WORD_VALID_OUT),
    .out_ready_in(WORD_READY_IN),
    .out_data_out(WORD_OUT)
  );

  assign HOST_RDATA_OUT = s_r.rdata;
  assign MEM_BUSY_OUT = s_r.mem_req;
  assign MEM_REQUEST_OUT = s_r.mem_req && (s_r.mst == MR_WAIT);
  assign RESULT_ADDRESS_OUT = {7'h00, s_r.next_index, 1'b0};
  assign SKIP_FETCH_OUT = s_r.byte_alt && (PHASE_IN != PHASE_DATA_A)
    && (PHASE_IN != PHASE_DATA_B);
  assign SIM_SERVICE_OUT_OUT = s_r.sim_channel_service_out;
  assign TIME_STEP_OUT = s_r.step;
  assign RESET_RECALL_OUT = s_r.reset_stored && (PHASE_IN == PHASE_RESET_USE);

  always_comb
  begin
    s_nxt = s_r;
    // host read path runs every clock, independent of time-state stepping
    case (HOST_REQ_IN.sel)
      SEL_CONTROL_BUFFER: s_nxt.rdata = cb_word;
      SEL_TRANSFER_DATA: s_nxt.rdata = s_r.xfer_word;
      SEL_EXTRA_ONE: s_nxt.rdata = es1_word;
      SEL_EXTRA_TWO: s_nxt.rdata = es2_word;
      default: s_nxt.rdata = RESET_WORD;
    endcase

    // memory transfer handshake; buffer back-pressure holds the wait state
    case (s_r.mst)
      MR_IDLE:
      begin
        if (MEM_START_IN)
        begin
          s_nxt.mem_req = 1'b1;
          s_nxt.dir = MEM_WRITE_IN;
          if (MEM_WRITE_IN)
            s_nxt.xfer_word = MEM_WDATA_IN;
          s_nxt.grant_cnt = '0;
          s_nxt.mst = MR_WAIT;
        end
      end
      MR_WAIT:
      begin
        if (!GRANT_IN)
        begin
          if (s_r.grant_cnt >= 32'(GRANT_TIMEOUT - 1))
            s_nxt.grant_err = 1'b1;
          else
            s_nxt.grant_cnt = s_r.grant_cnt + 32'h0000_0001;
        end
        if (MEM_DONE_IN && buf_in_ready)
        begin
          s_nxt.xfer_word = buf_word.data;
          s_nxt.mem_req = 1'b0;
          s_nxt.mst = MR_DONE;
        end
      end
      MR_DONE: s_nxt.mst = MR_IDLE;
      default: s_nxt.mst = MR_IDLE;
    endcase

    if (STATUS_PENDING_IN && dev_match)
      s_nxt.byte_alt = 1'b1;
    else if (((PHASE_IN == PHASE_DATA_A) || (PHASE_IN == PHASE_DATA_B)) && BYTE_STEP_IN)
      s_nxt.byte_alt = !s_r.byte_alt;

    // online level is a single register stage of the program request, one clock behind
    s_nxt.online_lvl = ONLINE_REQUEST_IN;

    // program response watchdog; any host access restarts it
    if (!channel_operational_in || HOST_STROBE_IN || s_r.timer_dis)
      s_nxt.resp_cnt = '0;
    else if (s_r.resp_cnt >= 64'(RESP_TIMEOUT - 1))
      s_nxt.resp_err = 1'b1;
    else
      s_nxt.resp_cnt = s_r.resp_cnt + 64'h1;

    s_nxt.sim_channel_service_out = s_r.fast_test && channel_service_in;

    // time state advances freely unless maintenance clocking holds it
    s_nxt.step = !s_r.mclk_en || s_r.mclk_pulse;
    if (s_r.mclk_en && s_r.mclk_pulse)
      s_nxt.mclk_pulse = 1'b0;

    if (disc)
      s_nxt.disc_seen = 1'b1;
    if (chrst && (PHASE_IN == PHASE_RESET_SEEN))
      s_nxt.reset_stored = 1'b1;

    if (host_wr)
    begin
      case (HOST_REQ_IN.sel)
        SEL_EXTRA_ONE:
        begin
          s_nxt.next_index = HOST_REQ_IN.data[15:ES1_INDEX_LSB];
          // error flags are write-one-to-clear; a fresh event still wins
          if (HOST_REQ_IN.data[ES1_GRANT_ERR_BIT] && !grant_evt)
            s_nxt.grant_err = 1'b0;
          // a host access restarts the watchdog, so no set can coincide here
          if (HOST_REQ_IN.data[ES1_RESP_ERR_BIT])
            s_nxt.resp_err = 1'b0;
          s_nxt.timer_dis = HOST_REQ_IN.data[ES1_TIMER_DIS_BIT];
          s_nxt.fast_test = HOST_REQ_IN.data[ES1_FAST_TEST_BIT];
          // entry refused while online; leaving is always allowed
          s_nxt.mclk_en = HOST_REQ_IN.data[ES1_MCLK_EN_BIT]
            && (s_r.mclk_en || !s_r.online_lvl);
          if (HOST_REQ_IN.data[ES1_MCLK_PULSE_BIT] && s_r.mclk_en)
            s_nxt.mclk_pulse = 1'b1;
        end
        SEL_EXTRA_TWO:
        begin
          if (HOST_REQ_IN.data[ES2_DISCONNECT_BIT] && !disc)
            s_nxt.disc_seen = 1'b0;
          if (HOST_REQ_IN.data[ES2_RESET_STORED_BIT] && !chrst)
            s_nxt.reset_stored = 1'b0;
        end
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end

    if (CB_CLEAR_IN)
    begin
      s_nxt.mem_req = 1'b0;
      s_nxt.dir = 1'b0;
      s_nxt.byte_alt = 1'b0;
      s_nxt.mst = MR_IDLE;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      s_r <= '0;
      s_r.mst <= MR_IDLE;
      s_r.online_lvl <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  chk_match_nest: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    dev_match |-> cu_match) else $error("device match without unit match");
  chk_online_follow: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ##1 s_r.online_lvl == $past(ONLINE_REQUEST_IN)) else $error("online lag wrong");
  chk_clear_keeps: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CB_CLEAR_IN ##1 1'b1 |-> !s_r.mem_req && !s_r.byte_alt) else $error("clear failed");
  chk_pulse_once: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_r.mclk_en && s_r.mclk_pulse |=> s_r.step ##1 !s_r.mclk_pulse)
    else $error("maintenance pulse not single");
  chk_hold_state: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_r.mclk_en && !s_r.mclk_pulse |=> !s_r.step) else $error("step while held");
  chk_no_maint_on: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !s_r.mclk_en && s_r.online_lvl |=> !s_r.mclk_en) else $error("maint entered online");
  chk_fast_channel_service_out: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_r.fast_test && channel_service_in |=> s_r.sim_channel_service_out) else $error("no simulated service-out");
  chk_disc_set: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    disc |=> s_r.disc_seen) else $error("disconnect not recorded");
  chk_timer_off: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_r.timer_dis && !s_r.resp_err |=> !s_r.resp_err) else $error("timer not disabled");
  chk_req_drop: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    s_r.mst == MR_DONE |-> !s_r.mem_req) else $error("request held after done");

  // start in idle loads direction and raises the request on the next edge
  chk_dir_load: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (s_r.mst == MR_IDLE) && MEM_START_IN && !CB_CLEAR_IN
    |=> s_r.mem_req && (s_r.dir == $past(MEM_WRITE_IN)))
    else $error("transfer start not taken");

  // missing grant at the limit must latch the error
  chk_grant_late: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    grant_evt |=> s_r.grant_err)
    else $error("grant latency not flagged");

  // watchdog expiry latches the response error unless disabled
  chk_resp_late: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    channel_operational_in && !HOST_STROBE_IN && !s_r.timer_dis
    && (s_r.resp_cnt >= 64'(RESP_TIMEOUT - 1)) |=> s_r.resp_err)
    else $error("response latency not flagged");

  // channel reset is only remembered in the reset phase
  chk_reset_store: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    chrst && (PHASE_IN == PHASE_RESET_SEEN) |=> s_r.reset_stored)
    else $error("channel reset not stored");

  // byte step outside data phases must leave the alternator alone
  chk_alt_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    !STATUS_PENDING_IN && !CB_CLEAR_IN && (PHASE_IN != PHASE_DATA_A)
    && (PHASE_IN != PHASE_DATA_B) |=> s_r.byte_alt == $past(s_r.byte_alt))
    else $error("byte alternator moved outside data phase");
endmodule

// ### hdl/adapter_regs_pkg.sv
// shared types and constants for the adapter status and maintenance registers
package adapter_regs_pkg;

  // register selects on the host side
  localparam logic [2:0] SEL_CONTROL_BUFFER = 3'h0;
  localparam logic [2:0] SEL_TRANSFER_DATA = 3'h1;
  localparam logic [2:0] SEL_EXTRA_ONE = 3'h2;
  localparam logic [2:0] SEL_EXTRA_TWO = 3'h3;

  // control_buffer_status field positions
  localparam int CB_MEM_REQ_BIT = 5;
  localparam int CB_DIR_BIT = 4;
  localparam int CB_BYTE_ALT_BIT = 3;
  localparam int CB_ONLINE_BIT = 2;
  localparam int CB_CU_MATCH_BIT = 1;
  localparam int CB_DEV_MATCH_BIT = 0;

  // extra_signals_one field positions
  localparam int ES1_INDEX_LSB = 8;
  localparam int ES1_ODD_BIT = 6;
  localparam int ES1_GRANT_ERR_BIT = 5;
  localparam int ES1_RESP_ERR_BIT = 4;
  localparam int ES1_TIMER_DIS_BIT = 3;
  localparam int ES1_FAST_TEST_BIT = 2;
  localparam int ES1_MCLK_EN_BIT = 1;
  localparam int ES1_MCLK_PULSE_BIT = 0;

  // extra_signals_two field positions
  localparam int ES2_DISCONNECT_BIT = 1;
  localparam int ES2_RESET_STORED_BIT = 0;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  // timing at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESP_TIMEOUT_SEC = 5;
  localparam longint RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_SEC * 64'd1000000000 / CLK_PERIOD_NS;
  localparam int GRANT_TIMEOUT_US = 10;
  localparam int GRANT_TIMEOUT_CYCLES = GRANT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // adapter phases that matter here
  localparam logic [2:0] PHASE_RESET_SEEN = 3'h4;
  localparam logic [2:0] PHASE_RESET_USE = 3'h7;
  localparam logic [2:0] PHASE_DATA_A = 3'h5;
  localparam logic [2:0] PHASE_DATA_B = 3'h6;

  typedef struct packed {
    logic write;
    logic [2:0] sel;
    logic [15:0] data;
  } host_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic write;
  } mem_word_t;

  typedef enum logic [2:0] {
    MR_IDLE = 3'b001,
    MR_WAIT = 3'b010,
    MR_DONE = 3'b100
  } mem_state_t;

endpackage

// ### hdl/word_buffer.sv
// two-entry valid/ready buffer for transfer words
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
)
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_state_t;

  buf_state_t s_r;
  buf_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready_out = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (s_r.cnt != '0);
  assign out_data_out = s_r.mem[s_r.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data_in;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// ### hdl/pin_sync.sv
// three-stage pin synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  assign level_out = s_r.lvl;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3)
      s_nxt.lvl = s_r.s3;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// ### tb/mem_partner.sv
// host memory bus and word consumer model for the adapter
`timescale 1ns/1ps
module mem_partner #(
  parameter int GRANT_DELAY = 8,
  parameter logic [15:0] READ_WORD = 16'hc3a5
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic mem_request_in,
  input wire logic mem_busy_in,
  input wire logic hold_grant_in,
  input wire logic stall_in,
  output logic grant_out,
  output logic mem_done_out,
  output logic word_ready_out,
  output logic [15:0] rdata_out
);
  logic [7:0] wait_r;
  logic done_r;
  // done is held until the adapter drops its flag, as a full buffer may hold it off
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !mem_busy_in)
    begin
      wait_r <= 8'h00;
      done_r <= 1'b0;
    end
    else if (mem_request_in && !hold_grant_in && !done_r)
    begin
      if (wait_r == 8'(GRANT_DELAY))
        done_r <= 1'b1;
      else
        wait_r <= wait_r + 8'h01;
    end
  end
  assign grant_out = done_r & mem_busy_in;
  assign mem_done_out = done_r & mem_busy_in;
  // released data bus shows the inverse, not a stale copy
  assign rdata_out = mem_done_out ? READ_WORD : ~READ_WORD;
  assign word_ready_out = ~stall_in;
endmodule

// ### tb/testbench.sv
// self-checking bench for the adapter status and maintenance registers
`timescale 1ns/1ps
module testbench;
  import adapter_regs_pkg::*;
  localparam int GRANT_TO = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  host_req_t req = '0;
  logic strobe = 1'b0, cb_clear = 1'b0, online = 1'b0, mem_start = 1'b0, mem_write = 1'b0;
  logic pending = 1'b0, byte_step = 1'b0, opl = 1'b0, svc_in = 1'b0, disc = 1'b0;
  logic chrst = 1'b0, hold_grant = 1'b0, stall = 1'b0;
  logic [15:0] bsa = 16'h0000, wdata = 16'h0000, bus_out = 16'h0000, rdata, res_addr, v;
  logic [2:0] phase = 3'h0;
  logic grant, mem_done, word_ready, word_valid, busy, mem_req, skip, sim_so, tstep, recall;
  logic [15:0] mem_rdata;
  mem_word_t word;
  logic [15:0] got_q[$], exp_q[$];
  logic [15:0] cmp_bus[3] = '{16'h2c91, 16'h2c6e, 16'hd391};
  logic [15:0] cmp_exp[3] = '{16'h0003, 16'h0002, 16'h0000};
  int n_fail = 0;
  int check_count = 0;
  int k;

  always #25 clk = ~clk;

  adapter_status_regs #(.RESP_TIMEOUT(50), .GRANT_TIMEOUT(GRANT_TO)) dut_u (
    .CLK_IN(clk), .RSTN_IN(rstn), .HOST_REQ_IN(req), .HOST_STROBE_IN(strobe),
    .HOST_RDATA_OUT(rdata), .CB_CLEAR_IN(cb_clear), .ONLINE_REQUEST_IN(online),
    .BUFFER_START_ADDRESS_IN(bsa), .PHASE_IN(phase), .MEM_START_IN(mem_start),
    .MEM_WRITE_IN(mem_write), .MEM_WDATA_IN(wdata), .STATUS_PENDING_IN(pending),
    .BYTE_STEP_IN(byte_step), .BUS_OUT_IN(bus_out), .CU_ADDRESS_IN(8'h2c),
    .DEV_ADDRESS_IN(8'h91), .OPERATIONAL_IN_IN(opl), .SERVICE_IN_IN(svc_in),
    .DISCONNECT_IN(disc), .CHANNEL_RESET_IN(chrst), .GRANT_IN(grant),
    .MEM_RDATA_IN(mem_rdata), .MEM_DONE_IN(mem_done), .WORD_READY_IN(word_ready),
    .WORD_VALID_OUT(word_valid), .WORD_OUT(word), .MEM_BUSY_OUT(busy),
    .MEM_REQUEST_OUT(mem_req), .RESULT_ADDRESS_OUT(res_addr), .SKIP_FETCH_OUT(skip),
    .SIM_SERVICE_OUT_OUT(sim_so), .TIME_STEP_OUT(tstep), .RESET_RECALL_OUT(recall));

  mem_partner partner_u (
    .clk_in(clk), .rstn_in(rstn), .mem_request_in(mem_req), .mem_busy_in(busy),
    .hold_grant_in(hold_grant), .stall_in(stall), .grant_out(grant),
    .mem_done_out(mem_done), .word_ready_out(word_ready), .rdata_out(mem_rdata));

  always @(posedge clk)
    if (rstn && word_valid === 1'b1 && word_ready)
      got_q.push_back(word.data);

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // read data is registered, so it is taken one edge after the select
  task automatic rdchk(input string name, input logic [2:0] sel, input logic [15:0] mask,
                       input logic [15:0] exp);
    @(posedge clk);
    req <= '{1'b0, sel, 16'h0000};
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    @(negedge clk);
    v = rdata;
    chk(name, v & mask, exp);
  endtask

  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, sel, d};
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
  endtask

  task automatic xfer(input logic w, input logic [15:0] d);
    @(posedge clk);
    mem_write <= w;
    wdata <= d;
    mem_start <= 1'b1;
    @(posedge clk);
    mem_start <= 1'b0;
    exp_q.push_back(w ? d : 16'hc3a5);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("memory flag", {15'h0000, busy}, 16'h0000);
    cycles(2);
  endtask

  task automatic count_steps();
    k = 0;
    repeat (10)
    begin
      @(negedge clk);
      if (tstep === 1'b1)
        k++;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    cycles(16);
    rstn <= 1'b1;
    for (int s = 0; s < 4; s++)
      rdchk("reset value", 3'(s), 16'hffff, 16'h0000);
    for (int c = 0; c < 3; c++)
    begin
      cycles(1);
      bus_out <= cmp_bus[c];
      rdchk("address match", SEL_CONTROL_BUFFER, 16'h0003, cmp_exp[c]);
    end
    cycles(1);
    bsa <= 16'h0001;
    wr(SEL_EXTRA_ONE, 16'h5a00);
    rdchk("index and odd", SEL_EXTRA_ONE, 16'hffc0, 16'h5a40);
    chk("result address", res_addr, 16'h00b4);
    // single stepping, taken while off line
    wr(SEL_EXTRA_ONE, 16'h0002);
    cycles(3);
    count_steps();
    chk("held steps", 16'(k), 16'h0000);
    wr(SEL_EXTRA_ONE, 16'h0003);
    count_steps();
    chk("single step", 16'(k), 16'h0001);
    rdchk("pulse cleared", SEL_EXTRA_ONE, 16'h0003, 16'h0002);
    wr(SEL_EXTRA_ONE, 16'h0000);
    cycles(1);
    online <= 1'b1;
    cycles(4);
    rdchk("online level", SEL_CONTROL_BUFFER, 16'h0004, 16'h0004);
    wr(SEL_EXTRA_ONE, 16'h0002);
    rdchk("maint refused", SEL_EXTRA_ONE, 16'h0002, 16'h0000);
    cycles(1);
    bus_out <= 16'h2c91;
    pending <= 1'b1;
    cycles(2);
    pending <= 1'b0;
    rdchk("byte alternator set", SEL_CONTROL_BUFFER, 16'h000c, 16'h000c);
    chk("skip fetch", {15'h0000, skip}, 16'h0001);
    for (int p = 0; p < 2; p++)
    begin
      cycles(1);
      phase <= p[0] ? PHASE_DATA_B : PHASE_DATA_A;
      byte_step <= 1'b1;
      cycles(1);
      byte_step <= 1'b0;
      rdchk("byte half", SEL_CONTROL_BUFFER, 16'h0008, p[0] ? 16'h0008 : 16'h0000);
    end
    cycles(1);
    phase <= 3'h0;
    cb_clear <= 1'b1;
    cycles(1);
    cb_clear <= 1'b0;
    rdchk("clear keeps online", SEL_CONTROL_BUFFER, 16'h003c, 16'h0004);
    cycles(1);
    online <= 1'b0;
    bus_out <= 16'h0000;
    for (int t = 0; t < 2; t++)
    begin
      xfer(t[0], 16'h1e7d);
      rdchk("request and direction", SEL_CONTROL_BUFFER, 16'h0030,
            t[0] ? 16'h0030 : 16'h0020);
      wait_idle();
      rdchk("transfer word", SEL_TRANSFER_DATA, 16'hffff, t[0] ? 16'h1e7d : 16'hc3a5);
    end
    // receiver stalls: two words fit, the third transfer is held
    cycles(1);
    stall <= 1'b1;
    xfer(1'b1, 16'ha1b2);
    wait_idle();
    xfer(1'b1, 16'hb2c3);
    wait_idle();
    xfer(1'b1, 16'hc3d4);
    cycles(30);
    chk("held by full buffer", {15'h0000, busy}, 16'h0001);
    stall <= 1'b0;
    wait_idle();
    cycles(1);
    hold_grant <= 1'b1;
    xfer(1'b0, 16'h0000);
    cycles(GRANT_TO + 10);
    rdchk("grant latency", SEL_EXTRA_ONE, 16'h0020, 16'h0020);
    cycles(1);
    hold_grant <= 1'b0;
    wait_idle();
    wr(SEL_EXTRA_ONE, 16'h0020);
    rdchk("grant latency cleared", SEL_EXTRA_ONE, 16'h0020, 16'h0000);
    cycles(1);
    opl <= 1'b1;
    cycles(80);
    rdchk("response latency", SEL_EXTRA_ONE, 16'h0010, 16'h0010);
    wr(SEL_EXTRA_ONE, 16'h0018);
    cycles(80);
    rdchk("timer disabled", SEL_EXTRA_ONE, 16'h0018, 16'h0008);
    wr(SEL_EXTRA_ONE, 16'h0004);
    opl <= 1'b0;
    svc_in <= 1'b1;
    k = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (sim_so === 1'b1)
        k = 1;
    end
    chk("simulated service-out", 16'(k), 16'h0001);
    cycles(1);
    svc_in <= 1'b0;
    disc <= 1'b1;
    cycles(4);
    disc <= 1'b0;
    cycles(6);
    rdchk("disconnect seen", SEL_EXTRA_TWO, 16'h0002, 16'h0002);
    cycles(1);
    phase <= PHASE_RESET_SEEN;
    chrst <= 1'b1;
    cycles(4);
    chrst <= 1'b0;
    cycles(6);
    rdchk("reset stored", SEL_EXTRA_TWO, 16'h0001, 16'h0001);
    cycles(1);
    phase <= PHASE_RESET_USE;
    cycles(2);
    @(negedge clk);
    chk("reset recall", {15'h0000, recall}, 16'h0001);
    wr(SEL_EXTRA_TWO, 16'h0003);
    rdchk("extra two cleared", SEL_EXTRA_TWO, 16'h0003, 16'h0000);
    chk("word count", 16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      chk("buffered word", got_q[i], exp_q[i]);
    print_verdict();
  end
endmodule
